// ==== common/ptm_defs.svh ====
// Constants of the protection threshold monitor: map, fields, defaults, timing.
`ifndef PTM_DEFS_SVH
`define PTM_DEFS_SVH
// ==========================================
// Timing
`define PTM_CLK_NS 4
`define PTM_MS_NS 1000000
`define PTM_MIN_PULSE_NS 25
`define PTM_MIN_PULSE_CYC ((`PTM_MIN_PULSE_NS + `PTM_CLK_NS - 1) / `PTM_CLK_NS)
// ==========================================
// Register byte addresses
`define PTM_REG_CONTROL 8'h00
`define PTM_REG_STATUS 8'h04
`define PTM_REG_IRQ_STATUS 8'h08
`define PTM_REG_IRQ_CLEAR 8'h0C
`define PTM_REG_IRQ_ENABLE 8'h10
`define PTM_FCFG_BASE 8'h20
`define PTM_THR_BASE 8'h40
`define PTM_NCLS 6
`define PTM_NTHR 18
`define PTM_NEV 11
// ==========================================
// Control fields and reset value
`define PTM_CTL_ENABLE 0
`define PTM_CTL_RESTART 1
`define PTM_CONTROL_RST 1'h1
// ==========================================
// Fault class configuration fields
`define PTM_F_RETRIES 0
`define PTM_F_RETRY_DLY 8
`define PTM_F_FAULT_DLY 16
`define PTM_RETRY_INF 8'hFF
`define PTM_FCFG_LATCH 24'h000000
`define PTM_FCFG_INF 24'h0000FF
// ==========================================
// Fault classes
`define PTM_C_OV 0
`define PTM_C_UV 1
`define PTM_C_OC 2
`define PTM_C_PT 3
`define PTM_C_CT 4
`define PTM_C_TR 5
// ==========================================
// Threshold indexes
`define PTM_T_OV_WARN 0
`define PTM_T_OV_FAULT 1
`define PTM_T_UV_WARN 2
`define PTM_T_UV_FAULT 3
`define PTM_T_OC_WARN 4
`define PTM_T_OC_FAULT 5
`define PTM_T_PT_WARN 6
`define PTM_T_PT_FAULT 7
`define PTM_T_CT_WARN 8
`define PTM_T_CT_FAULT 9
`define PTM_T_TEMP_ON 10
`define PTM_T_TRAIN 11
`define PTM_T_VIN_ON 12
`define PTM_T_VIN_OFF 13
`define PTM_T_PG_ON 14
`define PTM_T_PG_OFF 15
`define PTM_T_DUTY_MIN 16
`define PTM_T_DUTY_MAX 17
// ==========================================
// Threshold defaults (percent, amps, degrees C, millivolts)
`define PTM_D_OV_WARN 16'h006B
`define PTM_D_OV_FAULT 16'h0078
`define PTM_D_UV_WARN 16'h005D
`define PTM_D_UV_FAULT 16'h0055
`define PTM_D_OC4_WARN 16'h00C8
`define PTM_D_OC4_FAULT 16'h00D4
`define PTM_D_OC3_WARN 16'h0096
`define PTM_D_OC3_FAULT 16'h009F
`define PTM_D_OC2_WARN 16'h0064
`define PTM_D_OC2_FAULT 16'h006A
`define PTM_D_PT_WARN 16'h0078
`define PTM_D_PT_FAULT 16'h007D
`define PTM_D_CT_WARN 16'h006E
`define PTM_D_CT_FAULT 16'h0078
`define PTM_D_TEMP_ON 16'h0064
`define PTM_D_TRAIN 16'h08CA
`define PTM_D_VIN_ON 16'h1130
`define PTM_D_VIN_OFF 16'h1068
`define PTM_D_PG_ON 16'h005F
`define PTM_D_PG_OFF 16'h005A
`define PTM_D_DUTY_MIN 16'h0000
`define PTM_D_DUTY_MAX 16'h0032
`define PTM_PCT_FULL 32'h00000064
`endif

// ==== common/ptm_pkg.sv ====
// Types shared by the protection threshold monitor.
package ptm_pkg;
  typedef logic [15:0] ptm_word_type;
  typedef enum logic [1:0] {ST_RUN, ST_RETRY_WAIT, ST_COOL, ST_LATCHED} ptm_state_type;
endpackage : ptm_pkg

// ==== hdl/ptm_cmp.sv ====
// Warning and fault comparator for one measured quantity.
`timescale 1ns/1ns
module ptm_cmp #(
  parameter bit OVER = 1'b1,
  parameter bit INCL = 1'b0
) (
  input wire logic [31:0] value,
  input wire logic [31:0] warn_th,
  input wire logic [31:0] fault_th,
  output logic warn,
  output logic fault
);
  // Over limits trip above (or at) the threshold, under limits below it.
  wire warn_hi = INCL ? (value >= warn_th) : (value > warn_th);
  wire fault_hi = INCL ? (value >= fault_th) : (value > fault_th);
  assign warn = OVER ? warn_hi : (value < warn_th);
  assign fault = OVER ? fault_hi : (value < fault_th);
endmodule : ptm_cmp

// ==== hdl/ptm_clamp.sv ====
// Duty cycle clamp with minimum pulse width.
`timescale 1ns/1ns
`include "ptm_defs.svh"
module ptm_clamp (
  input wire logic enable,
  input wire logic [15:0] period,
  input wire logic [15:0] req,
  input wire logic [15:0] min_pct,
  input wire logic [15:0] max_pct,
  output logic [15:0] duty
);
  localparam logic [15:0] MIN_PULSE = 16'(`PTM_MIN_PULSE_CYC);
  // Percent limits scaled to clock cycles of one PWM period.
  wire [31:0] lo_w = (32'(period) * 32'(min_pct)) / `PTM_PCT_FULL;
  wire [31:0] hi_w = (32'(period) * 32'(max_pct)) / `PTM_PCT_FULL;
  wire [15:0] lo = lo_w[15:0];
  wire [15:0] hi = hi_w[15:0];
  wire [15:0] r = (req < lo) ? lo : ((req > hi) ? hi : req);
  // A pulse too short to emit is dropped, or raised when a floor is set.
  wire short_p = (r != 16'h0000) && (r < MIN_PULSE);
  wire [15:0] fixed = (lo != 16'h0000) ? MIN_PULSE : 16'h0000;
  assign duty = !enable ? 16'h0000 : (short_p ? fixed : r);
endmodule : ptm_clamp

// ==== hdl/ptm_monitor.sv ====
// Protection threshold monitor top with Avalon-MM register slave.
// What this block does
// - Vout over-voltage warn 107%, fault 120%.
// - Vout under-voltage warn 93%, fault 85%.
// - Over-current warn 200/150/100 A by phases.
// - Over-current fault 212/159/106 A by phases.
// - Power train warn 120 C, fault 125 C.
// - Stay off until below 100 C; retry forever.
// - Phase temperature input at 2.25 V faults.
// - Controller warn 110 C, fault 120 C.
// - Controller recovery shares power train level.
// - Duty clamped 0 to 50%, pulse >= 25 ns.
// - Power good on at 95%, off below 90%.
// - All limits but the 25 ns minimum pulse programmable; values are reset defaults.
`timescale 1ns/1ns
`include "ptm_defs.svh"
module ptm_monitor #(
  parameter int MS_CYCLES = `PTM_MS_NS / `PTM_CLK_NS
) (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic CE,
  input wire logic [7:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic [2:0] PHASE_COUNT,
  input wire ptm_pkg::ptm_word_type VOUT_SETPOINT_RESISTOR,
  input wire ptm_pkg::ptm_word_type VOUT_MEAS,
  input wire ptm_pkg::ptm_word_type VIN_MEAS,
  input wire ptm_pkg::ptm_word_type IOUT_MEAS,
  input wire logic [7:0] PT_TEMP,
  input wire logic [7:0] CTRL_TEMP,
  input wire logic [63:0] PHASE_TEMPERATURE_INPUTS,
  input wire ptm_pkg::ptm_word_type PWM_PERIOD,
  input wire ptm_pkg::ptm_word_type DUTY_REQ,
  output ptm_pkg::ptm_word_type DUTY_OUT,
  output logic OUTPUT_ENABLE,
  output logic POWER_GOOD,
  output logic IRQ
);
  import ptm_pkg::*;

  // Reset value of each threshold slot.
  function automatic ptm_word_type thr_rst(input int i);
    case (i)
      `PTM_T_OV_WARN: return `PTM_D_OV_WARN;
      `PTM_T_OV_FAULT: return `PTM_D_OV_FAULT;
      `PTM_T_UV_WARN: return `PTM_D_UV_WARN;
      `PTM_T_UV_FAULT: return `PTM_D_UV_FAULT;
      `PTM_T_OC_WARN: return `PTM_D_OC4_WARN;
      `PTM_T_OC_FAULT: return `PTM_D_OC4_FAULT;
      `PTM_T_PT_WARN: return `PTM_D_PT_WARN;
      `PTM_T_PT_FAULT: return `PTM_D_PT_FAULT;
      `PTM_T_CT_WARN: return `PTM_D_CT_WARN;
      `PTM_T_CT_FAULT: return `PTM_D_CT_FAULT;
      `PTM_T_TEMP_ON: return `PTM_D_TEMP_ON;
      `PTM_T_TRAIN: return `PTM_D_TRAIN;
      `PTM_T_VIN_ON: return `PTM_D_VIN_ON;
      `PTM_T_VIN_OFF: return `PTM_D_VIN_OFF;
      `PTM_T_PG_ON: return `PTM_D_PG_ON;
      `PTM_T_PG_OFF: return `PTM_D_PG_OFF;
      `PTM_T_DUTY_MIN: return `PTM_D_DUTY_MIN;
      default: return `PTM_D_DUTY_MAX;
    endcase
  endfunction : thr_rst

  // Byte-enable merge of a write into a stored word.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] m;
    m = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        m[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return m;
  endfunction : merge

  // ==========================================
  // Storage
  ptm_word_type thr [0:`PTM_NTHR-1];
  logic [23:0] fcfg [0:`PTM_NCLS-1];
  logic ctl_en;
  logic [`PTM_NEV-1:0] irq_status;
  logic [`PTM_NEV-1:0] irq_enable;
  logic ack;
  logic [31:0] rdata;
  logic oc_loaded;
  logic [17:0] ms_cnt;
  ptm_state_type state;
  logic [2:0] cause;
  logic [7:0] dly_cnt;
  logic [7:0] budget;
  logic budget_valid;
  logic vin_ok;
  logic out_en;
  logic pgood;
  ptm_word_type duty_q;

  // ==========================================
  // Bus decode
  // Each access waits one cycle; the answer comes on the second edge.
  wire req = AVS_READ | AVS_WRITE;
  wire wr_go = AVS_WRITE & ack;
  assign AVS_WAITREQUEST = req & ~ack;
  wire [7:0] thr_off = AVS_ADDRESS - `PTM_THR_BASE;
  wire [7:0] fcfg_off = AVS_ADDRESS - `PTM_FCFG_BASE;
  wire [4:0] thr_idx = thr_off[6:2];
  wire [2:0] fcfg_idx = fcfg_off[4:2];
  wire aligned = (AVS_ADDRESS[1:0] == 2'h0);
  wire hit_thr = aligned && (AVS_ADDRESS >= `PTM_THR_BASE) && (thr_idx < 5'(`PTM_NTHR))
                 && (thr_off[7] == 1'b0);
  wire hit_fcfg = aligned && (AVS_ADDRESS >= `PTM_FCFG_BASE) && (fcfg_off < 8'h18);
  wire hit_ctl = AVS_ADDRESS == `PTM_REG_CONTROL;
  wire hit_sta = AVS_ADDRESS == `PTM_REG_STATUS;
  wire hit_ist = AVS_ADDRESS == `PTM_REG_IRQ_STATUS;
  wire hit_icl = AVS_ADDRESS == `PTM_REG_IRQ_CLEAR;
  wire hit_ien = AVS_ADDRESS == `PTM_REG_IRQ_ENABLE;
  wire [31:0] wmerge_thr = merge({16'h0000, thr[thr_idx]}, AVS_WRITEDATA, AVS_BYTEENABLE);
  wire [31:0] wmerge_fcfg = merge({8'h00, fcfg[fcfg_idx]}, AVS_WRITEDATA, AVS_BYTEENABLE);
  wire [31:0] wmerge_ien = merge(32'(irq_enable), AVS_WRITEDATA, AVS_BYTEENABLE);
  wire restart = wr_go && hit_ctl && AVS_BYTEENABLE[0] && AVS_WRITEDATA[`PTM_CTL_RESTART];
  wire [`PTM_NEV-1:0] clr = (wr_go && hit_icl) ? AVS_WRITEDATA[`PTM_NEV-1:0] : '0;

  // ==========================================
  // Comparators
  wire [31:0] vout_x100 = 32'(VOUT_MEAS) * `PTM_PCT_FULL;
  wire [31:0] setp = 32'(VOUT_SETPOINT_RESISTOR);
  wire [`PTM_NCLS-1:0] raw_w;
  wire [`PTM_NCLS-1:0] raw_f;
  wire [3:0] train_hit;

  ptm_cmp #(.OVER(1'b1), .INCL(1'b0)) u_ov (
    .value(vout_x100), .warn_th(setp * 32'(thr[`PTM_T_OV_WARN])),
    .fault_th(setp * 32'(thr[`PTM_T_OV_FAULT])),
    .warn(raw_w[`PTM_C_OV]), .fault(raw_f[`PTM_C_OV]));
  ptm_cmp #(.OVER(1'b0), .INCL(1'b0)) u_uv (
    .value(vout_x100), .warn_th(setp * 32'(thr[`PTM_T_UV_WARN])),
    .fault_th(setp * 32'(thr[`PTM_T_UV_FAULT])),
    .warn(raw_w[`PTM_C_UV]), .fault(raw_f[`PTM_C_UV]));
  ptm_cmp #(.OVER(1'b1), .INCL(1'b0)) u_oc (
    .value(32'(IOUT_MEAS)), .warn_th(32'(thr[`PTM_T_OC_WARN])),
    .fault_th(32'(thr[`PTM_T_OC_FAULT])),
    .warn(raw_w[`PTM_C_OC]), .fault(raw_f[`PTM_C_OC]));
  ptm_cmp #(.OVER(1'b1), .INCL(1'b1)) u_pt (
    .value(32'(PT_TEMP)), .warn_th(32'(thr[`PTM_T_PT_WARN])),
    .fault_th(32'(thr[`PTM_T_PT_FAULT])),
    .warn(raw_w[`PTM_C_PT]), .fault(raw_f[`PTM_C_PT]));
  ptm_cmp #(.OVER(1'b1), .INCL(1'b1)) u_ct (
    .value(32'(CTRL_TEMP)), .warn_th(32'(thr[`PTM_T_CT_WARN])),
    .fault_th(32'(thr[`PTM_T_CT_FAULT])),
    .warn(raw_w[`PTM_C_CT]), .fault(raw_f[`PTM_C_CT]));

  // any phase input reaching the level
  for (genvar p = 0; p < 4; p++) begin : g_train
    assign train_hit[p] = PHASE_TEMPERATURE_INPUTS[16*p +: 16] >= thr[`PTM_T_TRAIN];
  end
  assign raw_w[`PTM_C_TR] = 1'b0;
  assign raw_f[`PTM_C_TR] = |train_hit;

  // ==========================================
  // Millisecond tick for fault and retry delays
  wire ms_tick = ms_cnt == 18'(MS_CYCLES - 1);
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      ms_cnt <= 18'h00000;
    end else if (CE) begin
      ms_cnt <= ms_tick ? 18'h00000 : ms_cnt + 18'h00001;
    end
  end

  // Fault qualification: the condition must persist for the fault delay.
  wire [`PTM_NCLS-1:0] fault_q;
  for (genvar k = 0; k < `PTM_NCLS; k++) begin : g_fdly
    logic [7:0] fcnt;
    assign fault_q[k] = raw_f[k] && (fcnt >= fcfg[k][`PTM_F_FAULT_DLY +: 8]);
    always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
        fcnt <= 8'h00;
      end else if (CE) begin
        if (!raw_f[k]) begin
          fcnt <= 8'h00;
        end else if (ms_tick && fcnt != 8'hFF) begin
          fcnt <= fcnt + 8'h01;
        end
      end
    end
  end

  // Lowest class index wins when several faults arrive together.
  logic [2:0] sel;
  always_comb begin
    sel = 3'h0;
    for (int k = `PTM_NCLS - 1; k >= 0; k--) begin
      if (fault_q[k]) begin
        sel = 3'(k);
      end
    end
  end

  // ==========================================
  // Retry sequencer
  wire any_fault = |fault_q;
  wire [7:0] retry_dly = fcfg[cause][`PTM_F_RETRY_DLY +: 8];
  // one re-enable level for both temperature sources
  wire cool_ok = (cause == 3'(`PTM_C_PT)) ? (16'(PT_TEMP) < thr[`PTM_T_TEMP_ON]) :
                 (cause == 3'(`PTM_C_CT)) ? (16'(CTRL_TEMP) < thr[`PTM_T_TEMP_ON]) : 1'b1;
  wire infinite = budget == `PTM_RETRY_INF;

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      state <= ST_RUN;
      cause <= 3'h0;
      dly_cnt <= 8'h00;
      budget <= 8'h00;
      budget_valid <= 1'b0;
    end else if (CE) begin
      unique case (state)
        ST_RUN: begin
          // a fault takes the output down
          if (any_fault) begin
            cause <= sel;
            dly_cnt <= 8'h00;
            state <= ST_RETRY_WAIT;
            if (!budget_valid || sel != cause) begin
              budget <= fcfg[sel][`PTM_F_RETRIES +: 8];
              budget_valid <= 1'b1;
            end
          end
        end
        ST_RETRY_WAIT: begin
          if (dly_cnt >= retry_dly) begin
            state <= ST_COOL;
          end else if (ms_tick) begin
            dly_cnt <= dly_cnt + 8'h01;
          end
        end
        ST_COOL: begin
          // zero latches, infinite never runs out
          if (cool_ok) begin
            if (infinite) begin
              state <= ST_RUN;
            end else if (budget == 8'h00) begin
              state <= ST_LATCHED;
            end else begin
              budget <= budget - 8'h01;
              state <= ST_RUN;
            end
          end
        end
        ST_LATCHED: begin
          if (restart) begin
            budget_valid <= 1'b0;
            state <= ST_RUN;
          end
        end
      endcase
    end
  end

  // ==========================================
  // Input hysteresis, output enable and power good
  wire vin_up = VIN_MEAS > thr[`PTM_T_VIN_ON];
  wire vin_down = VIN_MEAS < thr[`PTM_T_VIN_OFF];
  wire pg_up = vout_x100 >= setp * 32'(thr[`PTM_T_PG_ON]);
  wire pg_down = vout_x100 < setp * 32'(thr[`PTM_T_PG_OFF]);
  wire next_out_en = ctl_en && vin_ok && (state == ST_RUN) && !any_fault;
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      vin_ok <= 1'b0;
      out_en <= 1'b0;
      pgood <= 1'b0;
    end else if (CE) begin
      vin_ok <= vin_up ? 1'b1 : (vin_down ? 1'b0 : vin_ok);
      out_en <= next_out_en;
      pgood <= (!out_en || pg_down) ? 1'b0 : (pg_up ? 1'b1 : pgood);
    end
  end
  assign OUTPUT_ENABLE = out_en;
  assign POWER_GOOD = pgood;

  ptm_word_type duty_c;
  ptm_clamp u_clamp (
    .enable(out_en), .period(PWM_PERIOD), .req(DUTY_REQ),
    .min_pct(thr[`PTM_T_DUTY_MIN]), .max_pct(thr[`PTM_T_DUTY_MAX]), .duty(duty_c));
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      duty_q <= 16'h0000;
    end else if (CE) begin
      duty_q <= duty_c;
    end
  end
  assign DUTY_OUT = duty_q;

  // ==========================================
  // Events and interrupt
  wire [`PTM_NEV-1:0] ev = {fault_q[`PTM_C_TR], fault_q[`PTM_C_CT], raw_w[`PTM_C_CT],
                            fault_q[`PTM_C_PT], raw_w[`PTM_C_PT], fault_q[`PTM_C_OC],
                            raw_w[`PTM_C_OC], fault_q[`PTM_C_UV], raw_w[`PTM_C_UV],
                            fault_q[`PTM_C_OV], raw_w[`PTM_C_OV]};
  // warnings only set flags; set wins over clear.
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      irq_status <= '0;
    end else if (CE) begin
      irq_status <= (irq_status & ~clr) | ev;
    end
  end
  assign IRQ = |(irq_status & irq_enable);

  // ==========================================
  // Register writes
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      ctl_en <= `PTM_CONTROL_RST;
      irq_enable <= '0;
    end else if (CE && wr_go) begin
      if (hit_ctl && AVS_BYTEENABLE[0]) begin
        ctl_en <= AVS_WRITEDATA[`PTM_CTL_ENABLE];
      end
      if (hit_ien) begin
        irq_enable <= wmerge_ien[`PTM_NEV-1:0];
      end
    end
  end

  // thresholds reset to defaults and stay writable
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      for (int i = 0; i < `PTM_NTHR; i++) begin
        thr[i] <= thr_rst(i);
      end
      oc_loaded <= 1'b0;
    end else if (CE) begin
      if (!oc_loaded) begin
        // current defaults follow the phase strap
        oc_loaded <= 1'b1;
        thr[`PTM_T_OC_WARN] <= (PHASE_COUNT == 3'h3) ? `PTM_D_OC3_WARN :
                               (PHASE_COUNT == 3'h2) ? `PTM_D_OC2_WARN : `PTM_D_OC4_WARN;
        thr[`PTM_T_OC_FAULT] <= (PHASE_COUNT == 3'h3) ? `PTM_D_OC3_FAULT :
                                (PHASE_COUNT == 3'h2) ? `PTM_D_OC2_FAULT : `PTM_D_OC4_FAULT;
      end else if (wr_go && hit_thr) begin
        thr[thr_idx] <= wmerge_thr[15:0];
      end
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      for (int k = 0; k < `PTM_NCLS; k++) begin
        fcfg[k] <= (k == `PTM_C_PT || k == `PTM_C_CT) ? `PTM_FCFG_INF : `PTM_FCFG_LATCH;
      end
    end else if (CE && wr_go && hit_fcfg) begin
      fcfg[fcfg_idx] <= wmerge_fcfg[23:0];
    end
  end

  // ==========================================
  // Read data and handshake
  wire [31:0] status = {8'h00, cause, state != ST_RUN, state == ST_LATCHED, pgood, vin_ok,
                        out_en, 5'h00, ev};
  wire [31:0] rmux = hit_ctl ? {31'h0, ctl_en} :
                     hit_sta ? status :
                     hit_ist ? 32'(irq_status) :
                     hit_ien ? 32'(irq_enable) :
                     hit_thr ? 32'(thr[thr_idx]) :
                     hit_fcfg ? 32'(fcfg[fcfg_idx]) : 32'h00000000;
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      ack <= 1'b0;
      rdata <= 32'h00000000;
    end else if (CE) begin
      ack <= req & ~ack;
      if (AVS_READ && !ack) begin
        rdata <= rmux;
      end
    end
  end
  assign AVS_READDATA = rdata;
endmodule : ptm_monitor

// ==== bench/ptm_monitor_properties.sv ====
// Port-level concurrent checks of the protection threshold monitor.
`timescale 1ns/1ns
`include "ptm_defs.svh"
module ptm_props (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic AVS_WAITREQUEST,
  input wire logic [2:0] PHASE_COUNT,
  input wire ptm_pkg::ptm_word_type VOUT_SETPOINT_RESISTOR,
  input wire ptm_pkg::ptm_word_type VOUT_MEAS,
  input wire ptm_pkg::ptm_word_type VIN_MEAS,
  input wire ptm_pkg::ptm_word_type IOUT_MEAS,
  input wire logic [7:0] PT_TEMP,
  input wire logic [7:0] CTRL_TEMP,
  input wire logic [63:0] PHASE_TEMPERATURE_INPUTS,
  input wire ptm_pkg::ptm_word_type PWM_PERIOD,
  input wire ptm_pkg::ptm_word_type DUTY_OUT,
  input wire logic OUTPUT_ENABLE,
  input wire logic POWER_GOOD
);
  import ptm_pkg::*;
  // ==========================================
  // Scaled values
  // Output voltage in percent units, current limit by phases, train trip.
  wire logic [31:0] vo_pct = {16'h0000, VOUT_MEAS} * 32'h00000064;
  wire logic [31:0] set_w = {16'h0000, VOUT_SETPOINT_RESISTOR};
  wire logic [15:0] oc_lim = (PHASE_COUNT == 3'h2) ? `PTM_D_OC2_FAULT :
    (PHASE_COUNT == 3'h3) ? `PTM_D_OC3_FAULT : `PTM_D_OC4_FAULT;
  wire logic train = (PHASE_TEMPERATURE_INPUTS[15:0] >= `PTM_D_TRAIN) ||
    (PHASE_TEMPERATURE_INPUTS[31:16] >= `PTM_D_TRAIN) ||
    (PHASE_TEMPERATURE_INPUTS[47:32] >= `PTM_D_TRAIN) ||
    (PHASE_TEMPERATURE_INPUTS[63:48] >= `PTM_D_TRAIN);
  // ==========================================
  // Assertions
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RSTN);
  a_bus_one_wait: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("bus wait longer than one cycle");
  a_bus_idle: assert property (!(AVS_READ || AVS_WRITE) |-> !AVS_WAITREQUEST)
    else $error("wait raised without request");
  a_ov_fault: assert property (vo_pct > set_w * `PTM_D_OV_FAULT |=> !OUTPUT_ENABLE)
    else $error("output kept on over voltage");
  a_oc_fault: assert property (IOUT_MEAS > oc_lim |=> !OUTPUT_ENABLE)
    else $error("output kept on over current");
  a_pt_fault: assert property (PT_TEMP >= `PTM_D_PT_FAULT |=> !OUTPUT_ENABLE)
    else $error("output kept on train heat");
  a_ct_fault: assert property (CTRL_TEMP >= `PTM_D_CT_FAULT |=> !OUTPUT_ENABLE)
    else $error("output kept on controller heat");
  a_train_fault: assert property (train |=> !OUTPUT_ENABLE)
    else $error("output kept on train fault");
  a_vin_off: assert property (VIN_MEAS < `PTM_D_VIN_OFF [*2] |=> !OUTPUT_ENABLE)
    else $error("output kept on low input");
  a_pg_off: assert property (vo_pct < set_w * `PTM_D_PG_OFF |=> !POWER_GOOD)
    else $error("power good kept below off level");
  a_duty_off: assert property (!OUTPUT_ENABLE [*2] |-> DUTY_OUT == 16'h0000)
    else $error("duty while output disabled");
  a_duty_max: assert property (1'b1 |=>
    {16'h0000, DUTY_OUT} * 32'h00000064 <= $past({16'h0000, PWM_PERIOD}) * 32'h00000032)
    else $error("duty above maximum");
  a_min_pulse: assert property (DUTY_OUT == 16'h0000 || DUTY_OUT >= `PTM_MIN_PULSE_CYC)
    else $error("pulse shorter than minimum");
endmodule : ptm_props
bind ptm_monitor ptm_props props_u (.*);

// ==== bench/ptm_monitor_tb.sv ====
// Self-checking testbench of the protection threshold monitor.
`timescale 1ns/1ns
`include "ptm_defs.svh"
module ptm_monitor_tb;
  import ptm_pkg::*;
  logic CLK = 1'b0, RSTN = 1'b0, CE = 1'b1, AVS_READ = 1'b0, AVS_WRITE = 1'b0;
  logic [7:0] AVS_ADDRESS = 8'h00;
  logic [31:0] AVS_WRITEDATA = 32'h00000000, AVS_READDATA;
  logic [3:0] AVS_BYTEENABLE = 4'hF;
  logic [2:0] PHASE_COUNT = 3'h4;
  ptm_word_type VOUT_SETPOINT_RESISTOR = 16'h03E8, VOUT_MEAS = 16'h03E8, VIN_MEAS = 16'h1388;
  ptm_word_type IOUT_MEAS = 16'h0032, PWM_PERIOD = 16'h0064, DUTY_REQ = 16'h0000, DUTY_OUT;
  logic [7:0] PT_TEMP = 8'h19, CTRL_TEMP = 8'h19;
  logic [63:0] PHASE_TEMPERATURE_INPUTS = {4{16'h01F4}};
  logic AVS_WAITREQUEST, OUTPUT_ENABLE, POWER_GOOD, IRQ;
  logic [31:0] exp_q [$];
  logic [16:0] seed = 17'h10C43;
  int errors = 0, check_count = 0;
  logic [15:0] fix [4] = '{16'h0006, 16'h0007, 16'h0032, 16'h0033};
  logic [15:0] defv [18] = '{`PTM_D_OV_WARN, `PTM_D_OV_FAULT, `PTM_D_UV_WARN, `PTM_D_UV_FAULT,
    `PTM_D_OC4_WARN, `PTM_D_OC4_FAULT, `PTM_D_PT_WARN, `PTM_D_PT_FAULT, `PTM_D_CT_WARN,
    `PTM_D_CT_FAULT, `PTM_D_TEMP_ON, `PTM_D_TRAIN, `PTM_D_VIN_ON, `PTM_D_VIN_OFF,
    `PTM_D_PG_ON, `PTM_D_PG_OFF, `PTM_D_DUTY_MIN, `PTM_D_DUTY_MAX};
  // Free-running 250 MHz clock.
  always #2 CLK = ~CLK;
  ptm_monitor #(.MS_CYCLES(10)) dut_u (.*);
  // ==========================================
  // Helpers
  function automatic logic [16:0] nxt(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction : nxt
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : stop_test
  task automatic reset_dut();
    @(posedge CLK);
    RSTN <= 1'b0;
    repeat (4) @(posedge CLK);
    RSTN <= 1'b1;
  endtask : reset_dut
  // One Avalon transfer held until waitrequest is seen low.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    AVS_WRITE <= w;
    AVS_READ <= !w;
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    do begin
      @(posedge CLK);
    end while (AVS_WAITREQUEST !== 1'b0);
    AVS_WRITE <= 1'b0;
    AVS_READ <= 1'b0;
    @(negedge CLK);
  endtask : bus
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h00000000);
  endtask : rd
  task automatic set_in(input int sel, input logic [15:0] v);
    @(posedge CLK);
    case (sel)
      0: VOUT_MEAS <= v;
      1: IOUT_MEAS <= v;
      2: PT_TEMP <= v[7:0];
      3: CTRL_TEMP <= v[7:0];
      4: PHASE_TEMPERATURE_INPUTS[47:32] <= v;
      default: VIN_MEAS <= v;
    endcase
  endtask : set_in
  // Waits up to n cycles for the output enable level, then compares.
  task automatic oe_is(input logic e, input int n);
    int k = 0;
    @(negedge CLK);
    while (OUTPUT_ENABLE !== e && k < n) begin
      @(negedge CLK);
      k++;
    end
    check("output enable", OUTPUT_ENABLE, e);
  endtask : oe_is
  task automatic step(input int sel, input logic [15:0] v, input logic pg, input logic e);
    set_in(sel, v);
    repeat (3) @(posedge CLK);
    @(negedge CLK);
    check(pg ? "power good" : "output enable", pg ? POWER_GOOD : OUTPUT_ENABLE, e);
  endtask : step
  // Near limit keeps running; the fault drops output, then recovery.
  task automatic trip(input int sel, input logic [15:0] near, bad, mid, good,
                      input logic [31:0] bits, input logic latch);
    step(sel, near, 1'b0, 1'b1);
    bus(1'b1, `PTM_REG_IRQ_CLEAR, 32'h000007FF);
    set_in(sel, bad);
    @(posedge CLK);
    oe_is(1'b0, 0);
    rd(`PTM_REG_IRQ_STATUS, bits);
    set_in(sel, mid);
    repeat (20) @(posedge CLK);
    oe_is(1'b0, 0);
    set_in(sel, good);
    if (latch) begin
      repeat (20) @(posedge CLK);
      oe_is(1'b0, 0);
      bus(1'b1, `PTM_REG_CONTROL, 32'h00000003);
    end
    oe_is(1'b1, 50);
  endtask : trip
  // Compares each completed read with the oldest noted expectation.
  always @(negedge CLK) begin
    if (AVS_READ === 1'b1 && AVS_WAITREQUEST === 1'b0 && exp_q.size() > 0) begin
      check($sformatf("read %h", AVS_ADDRESS), AVS_READDATA, exp_q.pop_front());
    end
  end
  // Cuts a hung run short.
  initial begin
    #40000;
    errors++;
    stop_test();
  end
  // ==========================================
  // Main sequence
  initial begin
    logic [15:0] r, e;
    for (int p = 2; p <= 4; p++) begin
      PHASE_COUNT <= 3'(p);
      reset_dut();
      rd(8'h50, p == 2 ? `PTM_D_OC2_WARN : p == 3 ? `PTM_D_OC3_WARN : `PTM_D_OC4_WARN);
      rd(8'h54, p == 2 ? `PTM_D_OC2_FAULT : p == 3 ? `PTM_D_OC3_FAULT : `PTM_D_OC4_FAULT);
    end
    for (int i = 0; i < 18; i++) rd(8'(`PTM_THR_BASE + 4 * i), defv[i]);
    for (int k = 0; k < 6; k++) rd(8'(`PTM_FCFG_BASE + 4 * k), (k == 3 || k == 4) ? 8'hFF : 8'h00);
    rd(`PTM_REG_CONTROL, 32'h00000001);
    rd(`PTM_REG_IRQ_ENABLE, 32'h00000000);
    rd(8'hFC, 32'h00000000);
    oe_is(1'b1, 50);
    $display("test defaults done");
    for (int i = 0; i < 12; i++) begin
      seed = nxt(seed);
      r = (i < 4) ? fix[i] : {10'h000, seed[5:0]};
      e = (r > `PTM_D_DUTY_MAX) ? `PTM_D_DUTY_MAX : r;
      if (e != 16'h0000 && e < `PTM_MIN_PULSE_CYC) e = 16'h0000;
      @(posedge CLK);
      DUTY_REQ <= r;
      repeat (2) @(posedge CLK);
      @(negedge CLK);
      check("duty", DUTY_OUT, e);
    end
    $display("test duty done");
    // warning flags only, interrupt masking and clearing
    bus(1'b1, `PTM_REG_IRQ_CLEAR, 32'h000007FF);
    step(0, 16'h0438, 1'b0, 1'b1);
    rd(`PTM_REG_IRQ_STATUS, 32'h00000001);
    bus(1'b1, `PTM_REG_IRQ_ENABLE, 32'h00000002);
    check("irq masked", IRQ, 1'b0);
    bus(1'b1, `PTM_REG_IRQ_ENABLE, 32'h00000001);
    check("irq raised", IRQ, 1'b1);
    set_in(0, 16'h03E8);
    bus(1'b1, `PTM_REG_IRQ_CLEAR, 32'h00000001);
    rd(`PTM_REG_IRQ_STATUS, 32'h00000000);
    check("irq cleared", IRQ, 1'b0);
    $display("test warning done");
    trip(0, 16'h04B0, 16'h04BA, 16'h04BA, 16'h03E8, 32'h00000003, 1'b1);
    trip(1, 16'h00D4, 16'h00D5, 16'h00D5, 16'h0032, 32'h00000030, 1'b1);
    trip(2, 16'h007C, 16'h007D, 16'h006E, 16'h0063, 32'h000000C0, 1'b0);
    trip(3, 16'h0077, 16'h0078, 16'h0069, 16'h0063, 32'h00000300, 1'b0);
    trip(4, 16'h08C9, 16'h08CA, 16'h08CA, 16'h01F4, 32'h00000400, 1'b1);
    bus(1'b1, `PTM_FCFG_BASE, `PTM_FCFG_INF);
    trip(0, 16'h04B0, 16'h04BA, 16'h04BA, 16'h03E8, 32'h00000003, 1'b0);
    $display("test faults done");
    bus(1'b1, 8'h60, 32'h0000003C);
    bus(1'b1, `PTM_REG_IRQ_CLEAR, 32'h000007FF);
    step(3, 16'h0046, 1'b0, 1'b1);
    rd(`PTM_REG_IRQ_STATUS, 32'h00000100);
    set_in(3, 16'h0019);
    step(5, 16'h10CC, 1'b0, 1'b1);
    step(5, 16'h105E, 1'b0, 1'b0);
    step(5, 16'h10CC, 1'b0, 1'b0);
    step(5, 16'h1131, 1'b0, 1'b1);
    step(0, 16'h0398, 1'b1, 1'b1);
    step(0, 16'h037A, 1'b1, 1'b0);
    step(0, 16'h03AC, 1'b1, 1'b0);
    step(0, 16'h03B6, 1'b1, 1'b1);
    $display("test hysteresis done");
    check("pending reads", exp_q.size(), 32'h00000000);
    stop_test();
  end
endmodule : ptm_monitor_tb
